// ==== rtl/alh_top.sv ====
// Purpose: Alarm log, blink-count alarm display and operating-hour meter
// Assumes: Touch and selector inputs are debounced and synchronous
// Notes:   Log and hours are mirrored out for external non-volatile storage
`timescale 1ns/1ps
module alh_top import alh_pkg::*; #(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic        power_on_i,
   input  wire logic        diag_mode_i,
   input  wire logic [3:0]  sel_pos_i,
   input  wire logic        touch_start_i,
   input  wire logic        touch_opt_i,
   input  wire logic        touch_other_i,
   input  wire logic        alarm_new_i,
   input  wire logic [7:0]  alarm_code_i,
   input  wire logic        ui_unconf_i,
   input  wire logic        prog_run_i,
   input  wire logic        pause_i,
   input  wire logic        delay_wait_i,
   input  wire logic        rinse_hold_i,
   input  wire logic        soak_i,
   input  wire logic        nv_load_i,
   input  wire logic [23:0] nv_log_i,
   input  wire logic [12:0] nv_hours_i,
   output logic             led_red_o,
   output logic             led_yellow_o,
   output logic             led_all_o,
   output logic             disp_en_o,
   output logic [7:0]       disp_digits_o,
   output logic             disp_mark_o,
   output logic             disp_err_o,
   output logic             normal_ui_o,
   output logic             alarm_det_en_o,
   output logic             nv_wr_o,
   output logic [23:0]      nv_log_o,
   output logic [12:0]      hours_o
);
   localparam int unsigned PW = $clog2(MS_CYCLES);

   alh_blink_if bif ();

   logic [PW-1:0] pre_r;
   logic          ms_tick;
   logic          start_q_r;
   logic          opt_q_r;
   logic          any_q_r;
   logic [3:0]    sel_q_r;
   logic [15:0]   hold_ms_r;
   logic [15:0]   boot_ms_r;
   logic [15:0]   win_ms_r;
   logic          arm_r;
   logic [15:0]   show_ms_r;
   logic [15:0]   step_ms_r;
   logic [1:0]    step_r;
   logic [1:0]    idx_r;
   logic [7:0]    log_r [LOG_DEPTH];
   logic [15:0]   wms_r;
   logic [11:0]   wsec_r;
   logic [12:0]   hours_r;
   logic [15:0]   cfg_ms_r;
   logic          cfg_ph_r;
   alh_mode_t     mode_r;
   alh_mode_t     mode_nxt;

   logic          touch_any;
   logic          combo;
   logic          rise_start;
   logic          rise_opt;
   logic          rise_any;
   logic          sel_chg;
   logic          boot_done;
   logic          at_log;
   logic          arm_ok;
   logic          hours_go;
   logic          quick_go;
   logic          clear_go;
   logic          quick_end;
   logic          hours_end;
   logic          step_end;
   logic          work;
   logic          showing;
   logic [15:0]   bcd;

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == 16'hffff) ? v : v + 16'h0001;
   endfunction : sat_inc

   function automatic logic [15:0] to_bcd(input logic [12:0] h);
      logic [3:0] th;
      logic [3:0] hu;
      logic [3:0] te;
      logic [3:0] un;
      th = 4'((h / 13'd1000) % 13'd10);
      hu = 4'((h / 13'd100) % 13'd10);
      te = 4'((h / 13'd10) % 13'd10);
      un = 4'(h % 13'd10);
      return {th, hu, te, un};
   endfunction : to_bcd

   // Single prescaler feeds every timer so all durations share one base
   assign ms_tick    = (pre_r == PW'(MS_CYCLES - 1));
   assign touch_any  = touch_start_i | touch_opt_i | touch_other_i;
   assign combo      = touch_start_i & touch_opt_i;
   assign rise_start = touch_start_i & ~start_q_r;
   assign rise_opt   = touch_opt_i & ~opt_q_r;
   // Per-sensor edges, so a press while other fingers are held still counts
   assign rise_any   = rise_start | rise_opt | (touch_other_i & ~any_q_r);
   assign sel_chg    = (sel_pos_i != sel_q_r);
   assign boot_done  = (boot_ms_r >= BOOT_MS);
   assign at_log     = diag_mode_i && (sel_pos_i == SEL_LOG);
   assign arm_ok     = arm_r && (win_ms_r <= ENTRY_WIN_MS);
   assign hours_go   = arm_ok && (sel_pos_i == SEL_HOURS)
                       && (hold_ms_r >= LONG_HOLD_MS);
   // A pending hour entry holds the same combo, so it blocks quick read
   assign quick_go   = boot_done && (hold_ms_r >= QUICK_HOLD_MS)
                       && !(arm_ok && sel_pos_i == SEL_HOURS);
   assign clear_go   = (mode_r == M_LOG) && at_log
                       && (hold_ms_r >= LONG_HOLD_MS);
   assign quick_end  = rise_any || (show_ms_r >= QUICK_SHOW_MS);
   assign hours_end  = rise_any || sel_chg;
   assign step_end   = ms_tick && (step_ms_r == HOUR_STEP_MS - 16'h0001);
   assign work       = prog_run_i && !diag_mode_i && !pause_i && !delay_wait_i
                       && !rinse_hold_i && !soak_i;
   assign showing    = (mode_r == M_LOG) || (mode_r == M_QUICK);
   assign bcd        = to_bcd(hours_r);

   always_comb begin
      mode_nxt = mode_r;
      if (!power_on_i) begin
         mode_nxt = M_NORMAL;
      end else begin
         unique case (mode_r)
            M_NORMAL: begin
               if (at_log)        mode_nxt = M_LOG;
               else if (hours_go) mode_nxt = M_HOURS;
               else if (quick_go) mode_nxt = M_QUICK;
            end
            M_LOG: begin
               if (!at_log)        mode_nxt = M_NORMAL;
               else if (clear_go)  mode_nxt = M_E00;
            end
            M_E00:   if (!at_log) mode_nxt = M_NORMAL;
            M_QUICK: begin
               if (at_log)         mode_nxt = M_LOG;
               else if (quick_end) mode_nxt = M_NORMAL;
            end
            M_HOURS: if (hours_end) mode_nxt = M_NORMAL;
            default: mode_nxt = M_NORMAL;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_r     <= '0;
         start_q_r <= 1'b0;
         opt_q_r   <= 1'b0;
         any_q_r   <= 1'b0;
         sel_q_r   <= 4'h0;
         mode_r    <= M_NORMAL;
      end else begin
         pre_r     <= ms_tick ? '0 : pre_r + 1'b1;
         start_q_r <= touch_start_i;
         opt_q_r   <= touch_opt_i;
         any_q_r   <= touch_other_i;
         sel_q_r   <= sel_pos_i;
         mode_r    <= mode_nxt;
      end
   end

   // Hold, boot and entry-window timers
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hold_ms_r <= 16'h0000;
         boot_ms_r <= 16'h0000;
         win_ms_r  <= 16'h0000;
         arm_r     <= 1'b0;
      end else begin
         hold_ms_r <= !combo ? 16'h0000 : ms_tick ? sat_inc(hold_ms_r) : hold_ms_r;
         boot_ms_r <= (ms_tick && !boot_done) ? sat_inc(boot_ms_r) : boot_ms_r;
         if (sel_pos_i == SEL_OFF) begin
            arm_r    <= !touch_any;
            win_ms_r <= 16'h0000;
         end else begin
            arm_r    <= arm_r && (win_ms_r <= ENTRY_WIN_MS);
            win_ms_r <= ms_tick ? sat_inc(win_ms_r) : win_ms_r;
         end
      end
   end

   // Quick-read display time and hour display steps
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         show_ms_r <= 16'h0000;
         step_ms_r <= 16'h0000;
         step_r    <= 2'd0;
      end else begin
         show_ms_r <= (mode_r != M_QUICK) ? 16'h0000
                    : ms_tick ? sat_inc(show_ms_r) : show_ms_r;
         if (mode_r != M_HOURS) begin
            step_ms_r <= 16'h0000;
            step_r    <= 2'd0;
         end else if (step_end) begin
            step_ms_r <= 16'h0000;
            step_r    <= (step_r == 2'd2) ? 2'd0 : step_r + 2'd1;
         end else begin
            step_ms_r <= step_ms_r + {15'h0000, ms_tick};
         end
      end
   end

   // Log entry selection while the log is shown
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         idx_r <= 2'd0;
      end else if (mode_r != M_LOG) begin
         idx_r <= 2'd0;
      end else if (rise_start && !touch_opt_i) begin
         idx_r <= 2'd0;
      end else if (rise_opt && !touch_start_i
                   && idx_r != 2'(LOG_DEPTH - 1)) begin
         idx_r <= idx_r + 2'd1;
      end
   end

   // A new alarm in the clear cycle is kept: the event wins over the erase
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < LOG_DEPTH; i++) log_r[i] <= 8'h00;
         nv_wr_o <= 1'b0;
      end else begin
         nv_wr_o <= !nv_load_i && (clear_go || alarm_new_i);
         if (nv_load_i) begin
            for (int i = 0; i < LOG_DEPTH; i++) log_r[i] <= nv_log_i[8*i +: 8];
         end else if (alarm_new_i) begin
            // Shift starts at one so no index below zero is ever formed
            log_r[0] <= alarm_code_i;
            for (int i = 1; i < LOG_DEPTH; i++) log_r[i] <= clear_go ? 8'h00 : log_r[i-1];
         end else if (clear_go) begin
            for (int i = 0; i < LOG_DEPTH; i++) log_r[i] <= 8'h00;
         end
      end
   end

   // Working-time accumulator; sub-hour residue survives pauses
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wms_r   <= 16'h0000;
         wsec_r  <= 12'h000;
         hours_r <= 13'h0000;
      end else if (nv_load_i) begin
         wms_r   <= 16'h0000;
         wsec_r  <= 12'h000;
         hours_r <= (nv_hours_i > HOURS_MAX) ? HOURS_MAX : nv_hours_i;
      end else if (work && ms_tick) begin
         if (wms_r != SEC_MS - 16'h0001) begin
            wms_r <= wms_r + 16'h0001;
         end else begin
            wms_r <= 16'h0000;
            if (wsec_r != SEC_PER_HOUR - 12'h001) begin
               wsec_r <= wsec_r + 12'h001;
            end else begin
               wsec_r  <= 12'h000;
               hours_r <= (hours_r == HOURS_MAX) ? hours_r
                                                 : hours_r + 13'h0001;
            end
         end
      end
   end

   // Configuration error flash for all LEDs, same rhythm as code blinks
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_ms_r <= 16'h0000;
         cfg_ph_r <= 1'b0;
      end else if (!(showing && ui_unconf_i)) begin
         cfg_ms_r <= 16'h0000;
         cfg_ph_r <= 1'b0;
      end else if (ms_tick && cfg_ms_r == BLINK_ON_MS - 16'h0001) begin
         cfg_ms_r <= 16'h0000;
         cfg_ph_r <= ~cfg_ph_r;
      end else begin
         cfg_ms_r <= cfg_ms_r + {15'h0000, ms_tick};
      end
   end

   assign bif.ms_tick = ms_tick;
   assign bif.run     = showing && !ui_unconf_i;
   assign bif.code    = log_r[idx_r];

   alh_blink u_blink (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .sif     (bif)
   );

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         led_red_o     <= 1'b0;
         led_yellow_o  <= 1'b0;
         led_all_o     <= 1'b0;
         disp_en_o     <= 1'b0;
         disp_digits_o <= 8'h00;
         disp_mark_o   <= 1'b0;
         disp_err_o    <= 1'b0;
      end else begin
         led_red_o     <= bif.red;
         led_yellow_o  <= bif.yellow;
         led_all_o     <= showing && ui_unconf_i && !cfg_ph_r;
         disp_en_o     <= (mode_r == M_HOURS) || (mode_r == M_E00);
         disp_mark_o   <= (mode_r == M_HOURS) && (step_r == 2'd0);
         disp_err_o    <= (mode_r == M_E00);
         disp_digits_o <= (mode_r != M_HOURS) ? 8'h00
                        : (step_r == 2'd0) ? MARK_DIGITS
                        : (step_r == 2'd1) ? bcd[15:8] : bcd[7:0];
      end
   end

   // Detectors stay armed whenever diagnostics or a wash are active
   assign alarm_det_en_o = diag_mode_i || prog_run_i;
   assign normal_ui_o    = (mode_r == M_NORMAL) || (mode_r == M_QUICK);
   assign nv_log_o       = {log_r[2], log_r[1], log_r[0]};
   assign hours_o        = hours_r;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   sequence s_long_hold_log;
      mode_r == M_LOG && at_log && hold_ms_r >= LONG_HOLD_MS && power_on_i;
   endsequence
   sequence s_e00_shown;
      mode_r == M_E00 ##1 disp_err_o;
   endsequence

   AST_E00_SHOW: assert property (s_long_hold_log |=> s_e00_shown)
      else $error("E00 not shown after long hold");
   AST_CLEAR_ALL: assert property (clear_go && !alarm_new_i && !nv_load_i
      |=> log_r[0] == 8'h00 && log_r[1] == 8'h00 && log_r[2] == 8'h00)
      else $error("log not fully erased");
   AST_LOG_SHIFT: assert property (alarm_new_i && !nv_load_i && !clear_go
      |=> log_r[0] == $past(alarm_code_i) && log_r[1] == $past(log_r[0])
          && log_r[2] == $past(log_r[1]))
      else $error("log did not shift on new alarm");
   AST_HOURS_SAT: assert property (hours_r <= HOURS_MAX)
      else $error("hour counter above maximum");
   AST_DIAG_FROZEN: assert property (diag_mode_i && !nv_load_i
      |=> $stable(hours_r) && $stable(wms_r))
      else $error("hours advanced in diagnostics");
   AST_PAUSE_FROZEN: assert property ((pause_i || soak_i) && !nv_load_i
      |=> $stable(wsec_r) && $stable(wms_r))
      else $error("hours advanced while paused");
   AST_QUICK_BOOT: assert property (mode_r == M_NORMAL && mode_nxt == M_QUICK
      |-> boot_ms_r >= BOOT_MS && hold_ms_r >= QUICK_HOLD_MS)
      else $error("quick read without boot delay or hold");
   AST_NEWEST: assert property (mode_r == M_LOG && mode_nxt == M_LOG
      && rise_start && !touch_opt_i |=> idx_r == 2'd0)
      else $error("start touch did not return to newest");
   AST_STEP_WRAP: assert property (mode_r == M_HOURS && mode_nxt == M_HOURS
      && step_r == 2'd2 && step_end |=> step_r == 2'd0 ##1 disp_mark_o)
      else $error("hour display did not restart");
   AST_HOURS_EXIT: assert property (mode_r == M_HOURS && sel_chg
      |=> mode_r == M_NORMAL)
      else $error("hour display kept after selector turn");
   AST_HOUR_ENTRY: assert property (mode_r != M_HOURS && mode_nxt == M_HOURS
      |-> win_ms_r <= ENTRY_WIN_MS && hold_ms_r >= LONG_HOLD_MS)
      else $error("hour display entered outside window");
endmodule : alh_top

// ==== rtl/alh_pkg.sv ====
// Purpose: Constants and types for the alarm log and hour meter
// Assumes: 125 MHz system clock, one millisecond tick as time base
// Notes:   Durations are in milliseconds unless named otherwise
// Function
// - Keep three newest alarm codes in storage
// - Diagnostic position eleven shows newest alarm
// - Option touch steps older, start returns newest
// - Blinks 0.5 s on/off, 2.5 s pause, repeat
// - Red blinks family digit, yellow blinks number
// - Leading error letter is never shown
// - Family digit hexadecimal, A to F blink 10-15
// - Unconfigured interface blinks all LEDs together
// - All alarm detection enabled during diagnostics
// - After 10 s, 2 s combo hold shows alarm
// - Quick read keeps cycle; touch or timeout ends
// - Position eleven, 5 s combo hold shows E00
// - Clear erases every stored alarm entry
// - Hour counter saturates at 6550 hours
// - Hours count only in normal programmes
// - Pauses, delay, rinse hold, soak not counted
// - Per-programme time accurate within 30 s
// - Only completed hours reported, partial truncated
// - Position zero to five, 5 s hold, within 7 s
// - Hour display: intro, thousands/hundreds, tens/units
// - Hour display sequence repeats after last step
// - Off, any touch or selector turn exits
package alh_pkg;
   localparam int unsigned CLK_NS        = 8;
   localparam int unsigned MS_NS         = 1_000_000;
   localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_NS;
   localparam logic [15:0] BLINK_ON_MS   = 16'd500;
   localparam logic [15:0] BLINK_OFF_MS  = 16'd500;
   localparam logic [15:0] SEQ_PAUSE_MS  = 16'd2500;
   localparam logic [15:0] BOOT_MS       = 16'd10000;
   localparam logic [15:0] QUICK_HOLD_MS = 16'd2000;
   localparam logic [15:0] LONG_HOLD_MS  = 16'd5000;
   localparam logic [15:0] ENTRY_WIN_MS  = 16'd7000;
   localparam logic [15:0] HOUR_STEP_MS  = 16'd2000;
   localparam logic [15:0] QUICK_SHOW_MS = 16'd30000;
   localparam logic [15:0] SEC_MS        = 16'd1000;
   localparam logic [11:0] SEC_PER_HOUR  = 12'd3600;
   localparam logic [12:0] HOURS_MAX     = 13'd6550;
   localparam logic [3:0]  SEL_OFF       = 4'h0;
   localparam logic [3:0]  SEL_HOURS     = 4'h5;
   localparam logic [3:0]  SEL_LOG       = 4'hb;
   localparam int unsigned LOG_DEPTH     = 3;
   localparam logic [7:0]  MARK_DIGITS   = 8'hff;

   typedef enum logic [4:0] {
      M_NORMAL = 5'h01,
      M_LOG    = 5'h02,
      M_E00    = 5'h04,
      M_QUICK  = 5'h08,
      M_HOURS  = 5'h10
   } alh_mode_t;

   typedef enum logic [5:0] {
      S_IDLE    = 6'h01,
      S_RED_ON  = 6'h02,
      S_RED_OFF = 6'h04,
      S_YEL_ON  = 6'h08,
      S_YEL_OFF = 6'h10,
      S_PAUSE   = 6'h20
   } alh_blink_t;
endpackage : alh_pkg

// ==== rtl/alh_blink_if.sv ====
// Purpose: Carrier between the mode logic and the blink sequencer
// Assumes: Single clock domain
// Notes:   Code is the two digits after the error letter
`timescale 1ns/1ps
interface alh_blink_if;
   logic       ms_tick;
   logic       run;
   logic [7:0] code;
   logic       red;
   logic       yellow;
   modport ctl (output ms_tick, run, code, input red, yellow);
   modport seq (input ms_tick, run, code, output red, yellow);
endinterface : alh_blink_if

// ==== rtl/alh_blink.sv ====
// Purpose: Blink-count sequencer for a two-digit alarm code
// Assumes: One ms tick pulse per millisecond
// Notes:   A zero digit produces no blinks for that colour
`timescale 1ns/1ps
module alh_blink import alh_pkg::*; (
   input  wire logic   clock_i,
   input  wire logic   nrst_i,
   alh_blink_if.seq    sif
);
   alh_blink_t  st_r;
   alh_blink_t  st_nxt;
   logic [15:0] cnt_r;
   logic [3:0]  done_r;
   logic [3:0]  fam;
   logic [3:0]  num;
   logic        tick_end;
   logic        last;

   function automatic logic [15:0] dur(input alh_blink_t s);
      unique case (s)
         S_RED_ON, S_YEL_ON:   return BLINK_ON_MS;
         S_RED_OFF, S_YEL_OFF: return BLINK_OFF_MS;
         S_PAUSE:              return SEQ_PAUSE_MS;
         default:              return 16'h0001;
      endcase
   endfunction : dur

   // Only the two digits travel here, the letter has no path
   assign fam      = sif.code[7:4];
   assign num      = sif.code[3:0];
   assign tick_end = sif.ms_tick && (cnt_r == dur(st_r) - 16'h0001);
   assign last     = (st_r == S_RED_OFF) ? (done_r + 4'h1 == fam)
                                         : (done_r + 4'h1 == num);
   assign sif.red    = (st_r == S_RED_ON);
   assign sif.yellow = (st_r == S_YEL_ON);

   always_comb begin
      st_nxt = st_r;
      if (!sif.run) begin
         st_nxt = S_IDLE;
      end else begin
         unique case (st_r)
            S_IDLE, S_PAUSE: begin
               if (st_r == S_IDLE || tick_end) begin
                  st_nxt = (fam != 4'h0) ? S_RED_ON
                         : (num != 4'h0) ? S_YEL_ON : S_PAUSE;
               end
            end
            S_RED_ON:  if (tick_end) st_nxt = S_RED_OFF;
            S_RED_OFF: begin
               if (tick_end) begin
                  st_nxt = !last ? S_RED_ON
                         : (num != 4'h0) ? S_YEL_ON : S_PAUSE;
               end
            end
            S_YEL_ON:  if (tick_end) st_nxt = S_YEL_OFF;
            S_YEL_OFF: if (tick_end) st_nxt = last ? S_PAUSE : S_YEL_ON;
            default:   st_nxt = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r   <= S_IDLE;
         cnt_r  <= 16'h0000;
         done_r <= 4'h0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= (st_nxt != st_r) ? 16'h0000 : cnt_r + {15'h0000, sif.ms_tick};
         if (st_nxt == st_r)                         done_r <= done_r;
         else if (st_r == S_RED_OFF && !last)        done_r <= done_r + 4'h1;
         else if (st_r == S_YEL_OFF && !last)        done_r <= done_r + 4'h1;
         else if (st_r == S_RED_ON || st_r == S_YEL_ON) done_r <= done_r;
         else                                        done_r <= 4'h0;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   AST_LED_EXCL: assert property (!(sif.red && sif.yellow))
      else $error("red and yellow lit together");
   AST_PAUSE_DARK: assert property (st_r == S_PAUSE |-> !sif.red && !sif.yellow)
      else $error("light on during sequence pause");
   AST_FAM_DONE: assert property (sif.run && st_r == S_RED_OFF && tick_end && last
                                  |=> st_r != S_RED_ON)
      else $error("red blinked past family digit");
   AST_ON_LEN: assert property (st_r == S_RED_ON && st_nxt == S_RED_OFF && sif.run
                                |-> cnt_r == BLINK_ON_MS - 16'h0001)
      else $error("red on phase wrong length");
endmodule : alh_blink

// ==== tb/alh_panel.sv ====
// Purpose: Panel model, counts red and yellow blinks seen on the lights
// Assumes: Lights are registered outputs of the block
// Notes:   Counting rising edges makes the count immune to on-time drift
`timescale 1ns/1ps
module alh_panel (
   input  wire logic       clock_i,
   input  wire logic       clr_i,
   input  wire logic       red_i,
   input  wire logic       yel_i,
   output logic [7:0]      reds_o,
   output logic [7:0]      yels_o
);
   logic red_r;
   logic yel_r;
   always_ff @(posedge clock_i) begin
      red_r <= red_i;
      yel_r <= yel_i;
      reds_o <= clr_i ? 8'h00 : reds_o + 8'(red_i & ~red_r);
      yels_o <= clr_i ? 8'h00 : yels_o + 8'(yel_i & ~yel_r);
   end
endmodule : alh_panel

// ==== tb/test_alarm_log_and_hour_meter.sv ====
// Purpose: Self-checking bench for the alarm log and hour meter
// Assumes: MS_CYCLES shortened to 2 so long holds stay cheap
// Notes:   Hour counting itself needs hours of ticks, so hours are loaded
`timescale 1ns/1ps
module test_alarm_log_and_hour_meter;
   import alh_pkg::*;
   localparam int MS = 2;
   logic clk = 0, rn = 0, pw = 1, dg = 0, st = 0, op = 0, ot = 0, an = 0, ld = 0, pr = 0;
   logic z = 0, clr = 1, uc = 0, nu;
   logic [1:0] ps = 2'b00;
   logic [3:0] sel = 4'h0;
   logic [7:0] ac = 8'h00, reds, yels, dd;
   logic [23:0] nl = 24'h0, lg, lo;
   logic red, yel, lall, den, dmk, derr, wr, det;
   logic [12:0] hrs;
   int miscompares = 0, checks = 0;
   always #4 clk = ~clk;
   alh_top #(.MS_CYCLES(MS)) i_dut (.clock_i(clk), .nrst_i(rn), .power_on_i(pw),
      .diag_mode_i(dg), .sel_pos_i(sel), .touch_start_i(st), .touch_opt_i(op),
      .touch_other_i(ot), .alarm_new_i(an), .alarm_code_i(ac), .ui_unconf_i(uc),
      .prog_run_i(pr), .pause_i(ps[0]), .delay_wait_i(z), .rinse_hold_i(z), .soak_i(ps[1]),
      .nv_load_i(ld), .nv_log_i(nl), .nv_hours_i(13'h1fff), .led_red_o(red),
      .led_yellow_o(yel), .led_all_o(lall), .disp_en_o(den), .disp_digits_o(dd),
      .disp_mark_o(dmk), .disp_err_o(derr), .normal_ui_o(nu), .alarm_det_en_o(det),
      .nv_wr_o(wr), .nv_log_o(lo), .hours_o(hrs));
   alh_panel i_pan (.clock_i(clk), .clr_i(clr), .red_i(red), .yel_i(yel),
      .reds_o(reds), .yels_o(yels));
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
      ps = 2'($urandom);
   endtask : step
   task chk(input string n, input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (g !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         miscompares++;
      end
   endtask : chk
   function automatic logic [7:0] pair(input int h, input bit l);
      return l ? {4'(h / 10 % 10), 4'(h % 10)} : {4'(h / 1000 % 10), 4'(h / 100 % 10)};
   endfunction : pair
   task conclude;
      if (miscompares == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   initial begin
      #740_000;
      miscompares++;
      conclude();
   end
   initial begin
      void'($urandom(32'h5a8fef38));
      step(2);
      rn = 1;
      nl = 24'($urandom);
      ld = 1;
      step(1);
      ld = 0;
      step(1);
      chk("nv_log_o", nl, lo);
      chk("hours_o", 24'(HOURS_MAX), 24'(hrs));
      chk("alarm_det_en_o idle", 24'h0, 24'(det));
      lg = nl;
      for (int i = 0; i < 3; i++) begin
         ac = (i == 2) ? 8'ha3 : (i == 1) ? 8'h12 : 8'($urandom);
         an = 1;
         lg = {lg[15:0], ac};
         step(1);
         an = 0;
         chk("nv_wr_o", 24'h1, 24'(wr));
         chk("nv_log_o", lg, lo);
         step(1);
         chk("nv_wr_o idle", 24'h0, 24'(wr));
      end
      dg = 1;
      step(1);
      chk("alarm_det_en_o", 24'h1, 24'(det));
      // Working time runs outside diagnostics, paused at random
      pr = 1;
      sel = SEL_LOG;
      clr = 0;
      step(15500 * MS - 50);
      chk("red blinks", 24'd10, 24'(reds));
      chk("yellow blinks", 24'd3, 24'(yels));
      chk("led_all_o", 24'h0, 24'(lall));
      op = 1;
      step(1);
      {op, clr} = 2'b01;
      step(1);
      clr = 0;
      step(3000 * MS + 100);
      chk("older reds", 24'd1, 24'(reds));
      chk("older yellows", 24'd2, 24'(yels));
      st = 1;
      step(1);
      {st, clr} = 2'b01;
      step(1);
      clr = 0;
      step(3950 * MS);
      chk("newest reds", 24'd2, 24'(reds));
      st = 1;
      op = 1;
      step(5000 * MS + 20);
      chk("disp_err_o", 24'h1, 24'(derr));
      chk("nv_log_o cleared", 24'h0, lo);
      {st, op, dg} = 3'b000;
      sel = SEL_OFF;
      step(10);
      sel = SEL_HOURS;
      step(10);
      {st, op} = 2'b11;
      step(5000 * MS + 40);
      chk("intro mark", 24'h1, 24'({den, dmk}) & 24'h1);
      chk("intro digits", 24'(MARK_DIGITS), 24'(dd));
      step(2000 * MS);
      chk("thousands", 24'(pair(6550, 0)), 24'(dd));
      step(2000 * MS);
      chk("units", 24'(pair(6550, 1)), 24'(dd));
      step(2000 * MS);
      chk("repeat", 24'h1, 24'(dmk));
      ot = 1;
      step(3);
      chk("disp_en_o exit", 24'h0, 24'(den));
      {st, op, ot} = 3'b000;
      step(2);
      ot = 1;
      step(2);
      ot = 0;
      ac = 8'h21;
      an = 1;
      step(1);
      an = 0;
      chk("nv_log_o after clear", 24'h000021, lo);
      clr = 1;
      step(1);
      {clr, st, op} = 3'b011;
      step(2000 * MS + 10);
      {st, op} = 2'b00;
      step(2500 * MS);
      chk("quick reds", 24'd2, 24'(reds));
      chk("quick yellows", 24'd1, 24'(yels));
      chk("normal_ui_o", 24'h1, 24'(nu));
      uc = 1;
      step(10);
      chk("led_all_o on", 24'h1, 24'(lall));
      step(500 * MS);
      chk("led_all_o off", 24'h0, 24'(lall));
      step(500 * MS);
      chk("led_all_o again", 24'h1, 24'(lall));
      ot = 1;
      step(2);
      chk("led_all_o quick end", 24'h0, 24'(lall));
      conclude();
   end
endmodule : test_alarm_log_and_hour_meter
